// ==== common/tvd_regs.svh ====
// Register offsets, field positions, reset values and timing figures for the TV detect block.
// Assumes it is included by bare name from the design files.
`ifndef TVD_REGS_SVH
`define TVD_REGS_SVH

// Page select values of the register port.
`define TVD_PAGE1 1'b0
`define TVD_PAGE2 1'b1

// Register offsets.
`define TVD_ADDR_DAC_TRIM 8'h62
`define TVD_ADDR_ATTACH 8'h7E
`define TVD_ADDR_CHROMA_ORDER 8'h10

// Reset values.
`define TVD_DAC_TRIM_RST 8'h34
`define TVD_ATTACH_RST 8'h00
`define TVD_CHROMA_ORDER_RST 8'h00

// Field positions.
`define TVD_TRIGGER_BIT 7
`define TVD_SWAP_BIT 3
`define TVD_CHROMA_LSB 4
`define TVD_LUMA_LSB 2
`define TVD_COMPOSITE_LSB 0
`define TVD_UNMAPPED_RDATA 8'h00

// Detection codes.
`define TVD_CODE_NONE 2'h0
`define TVD_CODE_CONNECTED 2'h1
`define TVD_CODE_SHORTED 2'h2

// Timing: clock rate in MHz and detection pulse width in ns.
`define TVD_CLK_MHZ 10
`define TVD_PULSE_NS 2000

`endif

// ==== common/tvd_pkg.sv ====
// Types shared by the TV detect block.
// Assumes tvd_regs.svh is on the include path.
package tvd_pkg;
	typedef enum logic {TVD_IDLE, TVD_PULSE} tvd_state_t;
	typedef logic [1:0] tvd_code_t;
endpackage

// ==== common/tvd_det_if.sv ====
// Carrier between the register slice and the detection pulse generator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tvd_det_if;
	logic start;
	logic busy;
	logic [5:0] status;
	modport ctrl (output start, input busy, input status);
	modport det (input start, output busy, output status);
endinterface

// ==== hdl/tvd_sense_pulse.sv ====
// Detection pulse generator and per-channel status capture.
// Assumes load sense inputs are synchronous to clk and valid at the end of the pulse.
`timescale 1ns/100ps
`include "tvd_regs.svh"
module tvd_sense_pulse
	import tvd_pkg::*;
#(
	parameter int PULSE_NS = `TVD_PULSE_NS,
	parameter int CLK_MHZ = `TVD_CLK_MHZ
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Control side.
	tvd_det_if.det det,
	// DAC load sense.
	input wire logic [2:0] load_present,
	input wire logic [2:0] load_short,
	output logic dac_sense_pulse
);

	localparam int PULSE_RAW = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
	localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYC - 1);

	tvd_state_t state_q;
	logic [15:0] count_q;
	logic [5:0] code_d;
	logic [5:0] status_q;

	////////////////////////////////////////////////////////////////////////////////
	// A shorted output wins over a plain connection, so code 11 can never appear.
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++) begin : g_chan
			assign code_d[2*ch +: 2] = load_short[ch] ? `TVD_CODE_SHORTED :
				(load_present[ch] ? `TVD_CODE_CONNECTED : `TVD_CODE_NONE); // RULE1 RULE2 RULE3
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// A start that arrives during a pulse is dropped rather than stretching it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= TVD_IDLE;
			count_q <= 16'h0000;
		end else begin
			case (state_q)
				TVD_IDLE: begin
					if (det.start) begin
						state_q <= TVD_PULSE; // RULE8
						count_q <= 16'h0000;
					end
				end
				TVD_PULSE: begin
					if (count_q == PULSE_LAST) begin
						state_q <= TVD_IDLE;
					end else begin
						count_q <= count_q + 16'h0001;
					end
				end
				default: state_q <= TVD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= 6'h00;
		end else if (state_q == TVD_PULSE && count_q == PULSE_LAST) begin
			status_q <= code_d; // RULE9
		end
	end

	assign dac_sense_pulse = (state_q == TVD_PULSE); // RULE8
	assign det.busy = (state_q == TVD_PULSE);
	assign det.status = status_q;

endmodule

// ==== hdl/tvd_status_regs.sv ====
// TV connection detect status and chroma order control register slice.
// Assumes the serial port decoder presents page, index and one-cycle read and write strobes on clk.
//
// What this block does
// RULE1 - Chroma field reads 00 none, 01 connected, 10 shorted; never 11.
// RULE2 - Luma field in bits 3:2, same codes, 11 never used.
// RULE3 - Composite field in bits 1:0, same codes, 11 never used.
// RULE4 - Page-2 register 10h bit 3 exchanges Cr and Cb in 4:2:2 capture.
// RULE5 - Swap bit resets to 0, normal order; writing 1 selects swapped order.
// RULE6 - Other bits of register 10h are read/write reserved, reset to 0.
// RULE7 - Software sets trigger, reads the three fields, then clears trigger.
// RULE8 - Raising trigger bit 7 of register 62h fires one detection pulse; a raise while a pulse still runs fires none.
// RULE9 - Status fields hold the latest result, stable until the next pulse.
`timescale 1ns/100ps
`include "tvd_regs.svh"
module tvd_status_regs
	import tvd_pkg::*;
#(
	parameter int PULSE_NS = `TVD_PULSE_NS
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register port from the serial decoder.
	input wire logic reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// DAC load sense.
	input wire logic [2:0] load_present,
	input wire logic [2:0] load_short,
	output logic dac_sense_pulse,
	// 4:2:2 chroma capture.
	input wire logic [7:0] in_chroma_first,
	input wire logic [7:0] in_chroma_second,
	input wire logic in_pair_valid,
	output logic [7:0] out_cb,
	output logic [7:0] out_cr,
	output logic out_pair_valid,
	// Control levels.
	output logic chroma_order_swap,
	output logic detect_pulse_trigger
);

	logic [7:0] dac_trim_q;
	logic [7:0] chroma_order_control_q;
	logic [7:0] rdata_q;
	logic [7:0] cb_q;
	logic [7:0] cr_q;
	logic pair_valid_q;
	logic sel_trim;
	logic sel_attach;
	logic sel_order;
	logic [7:0] attach_view;

	tvd_det_if det_bus ();

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.
	always_comb begin
		sel_trim = 1'b0;
		sel_attach = 1'b0;
		sel_order = 1'b0;
		if (reg_page == `TVD_PAGE1 && reg_addr == `TVD_ADDR_DAC_TRIM) begin
			sel_trim = 1'b1;
		end else if (reg_page == `TVD_PAGE1 && reg_addr == `TVD_ADDR_ATTACH) begin
			sel_attach = 1'b1;
		end else if (reg_page == `TVD_PAGE2 && reg_addr == `TVD_ADDR_CHROMA_ORDER) begin
			sel_order = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DAC trim register; its reserved bits are kept so software reads back what it wrote.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dac_trim_q <= `TVD_DAC_TRIM_RST;
		end else if (reg_wr && sel_trim) begin
			dac_trim_q <= reg_wdata; // RULE7
		end
	end

	// Only the rising write of the trigger fires, and never while a pulse still runs.
	assign det_bus.start = reg_wr && sel_trim && reg_wdata[`TVD_TRIGGER_BIT]
		&& !dac_trim_q[`TVD_TRIGGER_BIT] && !det_bus.busy; // RULE8

	assign detect_pulse_trigger = dac_trim_q[`TVD_TRIGGER_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Chroma order register; reserved bits store as written.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chroma_order_control_q <= `TVD_CHROMA_ORDER_RST; // RULE5 RULE6
		end else if (reg_wr && sel_order) begin
			chroma_order_control_q <= reg_wdata; // RULE6
		end
	end

	assign chroma_order_swap = chroma_order_control_q[`TVD_SWAP_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Status view: upper two bits reserved and read as zero.
	assign attach_view = {2'b00, det_bus.status}; // RULE1 RULE2 RULE3 RULE9

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= `TVD_UNMAPPED_RDATA;
		end else if (reg_rd) begin
			if (sel_trim) begin
				rdata_q <= dac_trim_q;
			end else if (sel_attach) begin
				rdata_q <= attach_view; // RULE9
			end else if (sel_order) begin
				rdata_q <= chroma_order_control_q;
			end else begin
				rdata_q <= `TVD_UNMAPPED_RDATA;
			end
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Chroma capture. The swap bit is sampled per pair, so a change takes effect on the next
	// pair and never splits one.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cb_q <= 8'h00;
			cr_q <= 8'h00;
		end else if (in_pair_valid) begin
			if (chroma_order_swap) begin
				cb_q <= in_chroma_second; // RULE4
				cr_q <= in_chroma_first; // RULE4
			end else begin
				cb_q <= in_chroma_first; // RULE5
				cr_q <= in_chroma_second; // RULE5
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pair_valid_q <= 1'b0;
		end else begin
			pair_valid_q <= in_pair_valid;
		end
	end

	assign out_cb = cb_q;
	assign out_cr = cr_q;
	assign out_pair_valid = pair_valid_q;

	////////////////////////////////////////////////////////////////////////////////
	// Detection pulse generator.
	tvd_sense_pulse #(
		.PULSE_NS(PULSE_NS),
		.CLK_MHZ(`TVD_CLK_MHZ)
	) u_sense (
		.clk(clk),
		.reset_n(reset_n),
		.det(det_bus.det),
		.load_present(load_present),
		.load_short(load_short),
		.dac_sense_pulse(dac_sense_pulse)
	);

endmodule

// ==== tb/tvd_tv_model.sv ====
// TV set model on the DAC outputs.
// Assumes the bench chooses the load per channel.
`timescale 1ns/100ps
module tvd_tv_model (
	// Chosen load.
	input wire logic [2:0] cfg_present,
	input wire logic [2:0] cfg_short,
	// DAC side.
	input wire logic dac_sense_pulse,
	output logic [2:0] load_present,
	output logic [2:0] load_short
);
	// Outside a pulse the sense lines are junk, so early sampling shows up.
	assign load_present = dac_sense_pulse ? cfg_present : ~cfg_present;
	assign load_short = dac_sense_pulse ? cfg_short : ~cfg_short;
endmodule

// ==== tb/tvd_status_regs_chk.sv ====
// Port checker for the detect status slice.
// Assumes one clock domain at 100 ns.
`timescale 1ns/100ps
module tvd_status_regs_chk #(
	parameter int PULSE_NS = 2000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register port.
	input wire logic reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Levels and capture.
	input wire logic dac_sense_pulse,
	input wire logic chroma_order_swap,
	input wire logic detect_pulse_trigger,
	input wire logic [7:0] in_chroma_first,
	input wire logic [7:0] in_chroma_second,
	input wire logic in_pair_valid,
	input wire logic [7:0] out_cb,
	input wire logic out_pair_valid
);
	// A counter measures the pulse, since a long repetition would be unrolled.
	logic [7:0] cnt_q;
	logic trig_wr;
	assign trig_wr = reg_wr && !reg_page && reg_addr == 8'h62;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= dac_sense_pulse ? cnt_q + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_fire;
		trig_wr && reg_wdata[7] && !detect_pulse_trigger && !dac_sense_pulse;
	endsequence
	property p_fire; s_fire |=> dac_sense_pulse; endproperty
	a_fire: assert property (p_fire) else $error("no pulse");
	property p_width; $fell(dac_sense_pulse) |-> cnt_q == (PULSE_NS + 99) / 100; endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_trig; trig_wr |=> detect_pulse_trigger == $past(reg_wdata[7]); endproperty
	a_trig: assert property (p_trig) else $error("trigger bit");
	property p_swap; reg_wr && reg_page && reg_addr == 8'h10 |=> chroma_order_swap == $past(reg_wdata[3]); endproperty
	a_swap: assert property (p_swap) else $error("swap bit");
	property p_codes; reg_rd && !reg_page && reg_addr == 8'h7E |=> reg_rdata[7:6] == 2'h0
		&& reg_rdata[5:4] != 2'h3 && reg_rdata[3:2] != 2'h3 && reg_rdata[1:0] != 2'h3; endproperty
	a_codes: assert property (p_codes) else $error("bad code");
	property p_cap; in_pair_valid |=> out_pair_valid
		&& out_cb == ($past(chroma_order_swap) ? $past(in_chroma_second) : $past(in_chroma_first)); endproperty
	a_cap: assert property (p_cap) else $error("capture");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_init; $rose(reset_n) |-> !chroma_order_swap && !detect_pulse_trigger; endproperty
	a_init: assert property (p_init) else $error("reset levels");
endmodule
bind tvd_status_regs tvd_status_regs_chk #(.PULSE_NS(PULSE_NS)) u_chk (
	.clk(clk),
	.reset_n(reset_n),
	.reg_page(reg_page),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_wdata(reg_wdata),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.dac_sense_pulse(dac_sense_pulse),
	.chroma_order_swap(chroma_order_swap),
	.detect_pulse_trigger(detect_pulse_trigger),
	.in_chroma_first(in_chroma_first),
	.in_chroma_second(in_chroma_second),
	.in_pair_valid(in_pair_valid),
	.out_cb(out_cb),
	.out_pair_valid(out_pair_valid)
);

// ==== tb/test_tv_detect_status_and_chroma_swap.sv ====
// Self-checking bench for the detect status slice.
// Assumes the TV model on the DAC side; pulse cut to 5 cycles.
`timescale 1ns/100ps
module test_tv_detect_status_and_chroma_swap;
	logic clk = 1'b0, reset_n = 1'b0, reg_page = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, in_pair_valid = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, in_chroma_first = 8'h00, in_chroma_second = 8'h00;
	logic [7:0] reg_rdata, out_cb, out_cr;
	logic out_pair_valid, chroma_order_swap, detect_pulse_trigger, dac_sense_pulse;
	logic [2:0] cfg_present = 3'h0, cfg_short = 3'h0, load_present, load_short;
	int err_total = 0, num_checks = 0, n;
	// Rows: present, short, expected status.
	logic [13:0] rows [5] = '{14'h0000, 14'h3815, 14'h072A, 14'h3F2A, 14'h2A19};
	tvd_status_regs #(.PULSE_NS(500)) dut (
		.clk(clk),
		.reset_n(reset_n),
		.reg_page(reg_page),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.load_present(load_present),
		.load_short(load_short),
		.dac_sense_pulse(dac_sense_pulse),
		.in_chroma_first(in_chroma_first),
		.in_chroma_second(in_chroma_second),
		.in_pair_valid(in_pair_valid),
		.out_cb(out_cb),
		.out_cr(out_cr),
		.out_pair_valid(out_pair_valid),
		.chroma_order_swap(chroma_order_swap),
		.detect_pulse_trigger(detect_pulse_trigger)
	);
	tvd_tv_model tv (
		.cfg_present(cfg_present),
		.cfg_short(cfg_short),
		.dac_sense_pulse(dac_sense_pulse),
		.load_present(load_present),
		.load_short(load_short)
	);
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_page <= p;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic p, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_page <= p;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic detect();
		wr(1'b0, 8'h62, 8'hB4);
		#1 chk({7'h00, dac_sense_pulse}, 8'h01);
		chk({7'h00, detect_pulse_trigger}, 8'h01);
		n = 0;
		while (dac_sense_pulse !== 1'b0 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		chk(n[7:0], 8'h05);
		if (n == 40) end_of_test();
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(1'b0, 8'h62, 8'h34);
		rd(1'b0, 8'h7E, 8'h00);
		rd(1'b1, 8'h10, 8'h00);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			cfg_present <= rows[i][13:11];
			cfg_short <= rows[i][10:8];
			detect();
			rd(1'b0, 8'h7E, rows[i][7:0]);
			wr(1'b0, 8'h62, 8'h34);
		end
		// A second set while the bit is still 1 must not fire, and status must hold.
		detect();
		@(posedge clk);
		cfg_present <= 3'h0;
		wr(1'b0, 8'h62, 8'hB4);
		#1 chk({7'h00, dac_sense_pulse}, 8'h00);
		repeat (6) @(posedge clk);
		rd(1'b0, 8'h7E, 8'h19);
		wr(1'b0, 8'h62, 8'h34);
		wr(1'b1, 8'h10, 8'hFF);
		rd(1'b1, 8'h10, 8'hFF);
		rd(1'b0, 8'h10, 8'h00);
		for (int s = 0; s < 2; s++) begin
			wr(1'b1, 8'h10, s ? 8'h08 : 8'h00);
			@(posedge clk);
			in_chroma_first <= 8'hA5;
			in_chroma_second <= 8'h3C;
			in_pair_valid <= 1'b1;
			@(posedge clk);
			in_pair_valid <= 1'b0;
			#1 chk(out_cb, s ? 8'h3C : 8'hA5);
			chk(out_cr, s ? 8'hA5 : 8'h3C);
			chk({7'h00, out_pair_valid}, 8'h01);
			chk({7'h00, chroma_order_swap}, s ? 8'h01 : 8'h00);
		end
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(1'b1, 8'h10, 8'h00);
		chk({7'h00, chroma_order_swap}, 8'h00);
		end_of_test();
	end
endmodule
